// file: hdl/gpu_pkg.sv
package gpu_pkg;

    // ************************************************
    // Widths
    // ************************************************
    localparam int WORD_W  = 36;
    localparam int NFLAG   = 6;
    localparam int NLEVEL  = 3;
    localparam int NCTRL   = 6;
    localparam int AXI_AW  = 8;
    localparam int CNT_W   = 6;

    // ************************************************
    // Timing
    // ************************************************
    localparam int CLK_PERIOD_NS  = 8;
    localparam int T_SET_PULSE_NS = 100;
    localparam int T_SET_IDLE_NS  = 400;
    // Least times round up
    localparam logic [CNT_W-1:0] SET_PULSE_CYC =
        CNT_W'((T_SET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] SET_IDLE_CYC =
        CNT_W'((T_SET_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // ************************************************
    // Register map
    // ************************************************
    localparam logic [AXI_AW-1:0] OFS_DIN_LO  = 8'h00;
    localparam logic [AXI_AW-1:0] OFS_DIN_HI  = 8'h04;
    localparam logic [AXI_AW-1:0] OFS_SETREQ  = 8'h08;
    localparam logic [AXI_AW-1:0] OFS_LEVEL   = 8'h0C;
    localparam logic [AXI_AW-1:0] OFS_DOUT_LO = 8'h10;
    localparam logic [AXI_AW-1:0] OFS_DOUT_HI = 8'h14;
    localparam logic [AXI_AW-1:0] OFS_STAT    = 8'h18;

    localparam int STAT_CTRL_LSB = 0;
    localparam int STAT_EVT_LSB  = 8;
    localparam int NEVT          = 4;

    localparam logic [WORD_W-1:0] DIN_RST   = 36'h0_0000_0000;
    localparam logic [NLEVEL-1:0] LEVEL_RST = 3'h0;
    localparam logic [WORD_W-1:0] DOUT_RST  = 36'h0_0000_0000;
    localparam logic [NEVT-1:0]   EVT_RST   = 4'h0;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ************************************************
    // Pulses arriving from the interface
    // ************************************************
    typedef struct packed {
        logic input_complete;
        logic output_clear;
        logic output_load;
        logic general_reset;
        logic condition_clear;
        logic condition_load;
    } gpu_dev_pulse_t;

    typedef enum logic [1:0] {
        PS_WAIT = 2'b01,
        PS_HIGH = 2'b10
    } gpu_pstate_t;

    typedef enum logic [1:0] {
        BS_IDLE = 2'b01,
        BS_RESP = 2'b10
    } gpu_bstate_t;

endpackage

// file: hdl/gpu_set_pulser.sv
`timescale 1ns/1ps
module gpu_set_pulser
    import gpu_pkg::*;
(
    // Clock and reset
    input  wire logic             mclk_i,
    input  wire logic             rst_n_i,
    // Requests
    input  wire logic             clear_i,
    input  wire logic [NFLAG-1:0] req_i,
    output logic      [NFLAG-1:0] pending_o,
    // Set lines toward the interface
    output logic      [NFLAG-1:0] set_o
);

    // ************************************************
    // One pulse engine per flag
    // ************************************************
    genvar g;
    generate
        for (g = 0; g < NFLAG; g++) begin : g_flag
            gpu_pstate_t      st_reg;
            gpu_pstate_t      st_next;
            logic [CNT_W-1:0] cnt_reg;
            logic [CNT_W-1:0] cnt_next;
            logic             pend_reg;
            logic             pend_next;
            logic [CNT_W-1:0] lowrun_reg;

            always_comb begin
                st_next   = st_reg;
                cnt_next  = cnt_reg;
                // New request wins over a clear in the same cycle
                pend_next = (pend_reg & ~clear_i) | req_i[g];
                unique case (st_reg)
                    PS_WAIT: begin
                        if (cnt_reg < SET_IDLE_CYC) begin
                            cnt_next = cnt_reg + 1'b1;
                        end
                        // Line stays low for the idle time first
                        if (pend_reg && cnt_reg >= SET_IDLE_CYC) begin
                            st_next   = PS_HIGH;
                            cnt_next  = '0;
                            pend_next = req_i[g];
                        end
                    end
                    PS_HIGH: begin
                        // Never cut short, even by a general reset
                        if (cnt_reg == SET_PULSE_CYC - 1'b1) begin
                            st_next  = PS_WAIT;
                            cnt_next = '0;
                        end else begin
                            cnt_next = cnt_reg + 1'b1;
                        end
                    end
                    default: begin
                        st_next  = PS_WAIT;
                        cnt_next = '0;
                    end
                endcase
            end

            always_ff @(posedge mclk_i) begin
                if (!rst_n_i) begin
                    st_reg   <= PS_WAIT;
                    cnt_reg  <= '0;
                    pend_reg <= 1'b0;
                end else begin
                    st_reg   <= st_next;
                    cnt_reg  <= cnt_next;
                    pend_reg <= pend_next;
                end
            end

            // Unrequested lines stay low
            assign set_o[g]     = st_reg[1];
            assign pending_o[g] = pend_reg;

            // Helper for checking the idle time
            always_ff @(posedge mclk_i) begin
                if (!rst_n_i) begin
                    lowrun_reg <= '0;
                end else if (set_o[g]) begin
                    lowrun_reg <= '0;
                end else if (lowrun_reg != '1) begin
                    lowrun_reg <= lowrun_reg + 1'b1;
                end
            end

            a_set_width: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
                $rose(set_o[g]) |-> set_o[g] [*8] ##1 set_o[g] [*5] ##1 !set_o[g])
                else $error("Set pulse width is not 13 cycles");
            a_set_idle: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
                $rose(set_o[g]) |-> $past(lowrun_reg) >= SET_IDLE_CYC)
                else $error("Set line rose before 50 idle cycles");
            a_set_cause: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
                $rose(set_o[g]) |-> $past(pend_reg))
                else $error("Set pulse without a request");
        end
    endgenerate

endmodule

// file: hdl/gpu_user.sv
// Design decisions made here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
// How it works
// - Unused input word lines held at zero
// - Set line low 400 ns before rising
// - Unused set lines simply stay inactive
// - Clear our word, then load from bus
// - General reset returns input word, level and output word to start state
module gpu_user
    import gpu_pkg::*;
(
    // Clock and reset
    input  wire logic              mclk_i,
    input  wire logic              rst_n_i,
    // AXI4-Lite write
    input  wire logic [AXI_AW-1:0] s_axi_awaddr_i,
    input  wire logic              s_axi_awvalid_i,
    output logic                   s_axi_awready_o,
    input  wire logic [31:0]       s_axi_wdata_i,
    input  wire logic [3:0]        s_axi_wstrb_i,
    input  wire logic              s_axi_wvalid_i,
    output logic                   s_axi_wready_o,
    output logic [1:0]             s_axi_bresp_o,
    output logic                   s_axi_bvalid_o,
    input  wire logic              s_axi_bready_i,
    // AXI4-Lite read
    input  wire logic [AXI_AW-1:0] s_axi_araddr_i,
    input  wire logic              s_axi_arvalid_i,
    output logic                   s_axi_arready_o,
    output logic [31:0]            s_axi_rdata_o,
    output logic [1:0]             s_axi_rresp_o,
    output logic                   s_axi_rvalid_o,
    input  wire logic              s_axi_rready_i,
    // Interface pins
    output logic [WORD_W-1:0]      user_input_word_o,
    output logic [NFLAG-1:0]       status_set_o,
    output logic [NLEVEL-1:0]      status_level_o,
    input  wire logic [WORD_W-1:0] buffered_host_output_word_i,
    input  wire logic [NCTRL-1:0]  control_flag_out_i,
    input  wire gpu_dev_pulse_t    dev_pulse_i
);

    // ************************************************
    // Pulse edge detection
    // ************************************************
    gpu_dev_pulse_t pulse_prev_reg;
    gpu_dev_pulse_t pulse_edge;

    // Pins are synchronous, so a plain edge register suffices
    assign pulse_edge = dev_pulse_i & ~pulse_prev_reg;

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            pulse_prev_reg <= '0;
        end else begin
            pulse_prev_reg <= dev_pulse_i;
        end
    end

    // ************************************************
    // Write channel
    // ************************************************
    gpu_bstate_t       ws_reg, ws_next;
    logic              aw_got_reg, aw_got_next;
    logic              w_got_reg, w_got_next;
    logic [AXI_AW-1:0] waddr_reg, waddr_next;
    logic [31:0]       wdata_reg, wdata_next;
    logic [3:0]        wstrb_reg, wstrb_next;
    logic              awready_reg, awready_next;
    logic              wready_reg, wready_next;
    logic              bvalid_reg, bvalid_next;
    logic [1:0]        bresp_reg, bresp_next;
    logic              do_wr;
    logic [31:0]       wmask;

    function automatic logic map_hit(input logic [AXI_AW-1:0] a);
        map_hit = (a == OFS_DIN_LO) || (a == OFS_DIN_HI) || (a == OFS_SETREQ) ||
                  (a == OFS_LEVEL) || (a == OFS_DOUT_LO) || (a == OFS_DOUT_HI) ||
                  (a == OFS_STAT);
    endfunction

    always_comb begin
        ws_next      = ws_reg;
        aw_got_next  = aw_got_reg;
        w_got_next   = w_got_reg;
        waddr_next   = waddr_reg;
        wdata_next   = wdata_reg;
        wstrb_next   = wstrb_reg;
        awready_next = awready_reg;
        wready_next  = wready_reg;
        bvalid_next  = bvalid_reg;
        bresp_next   = bresp_reg;
        do_wr        = 1'b0;
        unique case (ws_reg)
            BS_IDLE: begin
                if (s_axi_awvalid_i && awready_reg) begin
                    aw_got_next  = 1'b1;
                    waddr_next   = s_axi_awaddr_i;
                    awready_next = 1'b0;
                end
                if (s_axi_wvalid_i && wready_reg) begin
                    w_got_next  = 1'b1;
                    wdata_next  = s_axi_wdata_i;
                    wstrb_next  = s_axi_wstrb_i;
                    wready_next = 1'b0;
                end
                if (aw_got_next && w_got_next) begin
                    do_wr       = 1'b1;
                    ws_next     = BS_RESP;
                    bvalid_next = 1'b1;
                    bresp_next  = map_hit(waddr_next) ? RESP_OKAY : RESP_SLVERR;
                end
            end
            BS_RESP: begin
                if (s_axi_bready_i) begin
                    ws_next      = BS_IDLE;
                    bvalid_next  = 1'b0;
                    aw_got_next  = 1'b0;
                    w_got_next   = 1'b0;
                    awready_next = 1'b1;
                    wready_next  = 1'b1;
                end
            end
            default: begin
                ws_next = BS_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            ws_reg      <= BS_IDLE;
            aw_got_reg  <= 1'b0;
            w_got_reg   <= 1'b0;
            waddr_reg   <= '0;
            wdata_reg   <= '0;
            wstrb_reg   <= '0;
            awready_reg <= 1'b1;
            wready_reg  <= 1'b1;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= RESP_OKAY;
        end else begin
            ws_reg      <= ws_next;
            aw_got_reg  <= aw_got_next;
            w_got_reg   <= w_got_next;
            waddr_reg   <= waddr_next;
            wdata_reg   <= wdata_next;
            wstrb_reg   <= wstrb_next;
            awready_reg <= awready_next;
            wready_reg  <= wready_next;
            bvalid_reg  <= bvalid_next;
            bresp_reg   <= bresp_next;
        end
    end

    genvar b;
    generate
        for (b = 0; b < 4; b++) begin : g_lane
            assign wmask[8*b +: 8] = {8{wstrb_next[b]}};
        end
    endgenerate

    // ************************************************
    // User registers
    // ************************************************
    logic [WORD_W-1:0] din_reg, din_next;
    logic [NLEVEL-1:0] level_reg, level_next;
    logic [WORD_W-1:0] dout_reg, dout_next;
    logic [NEVT-1:0]   evt_reg, evt_next;
    logic [NCTRL-1:0]  ctrl_reg;
    logic [NFLAG-1:0]  set_req;
    logic [NFLAG-1:0]  set_pending;
    logic [NEVT-1:0]   evt_in;

    // Events: read done, word loaded, general reset, condition load
    assign evt_in = {pulse_edge.condition_load, pulse_edge.general_reset,
                     pulse_edge.output_load, pulse_edge.input_complete};

    always_comb begin
        din_next   = din_reg;
        level_next = level_reg;
        dout_next  = dout_reg;
        evt_next   = evt_reg;
        set_req    = '0;
        if (do_wr) begin
            unique case (waddr_next)
                OFS_DIN_LO: din_next[31:0] = (din_reg[31:0] & ~wmask) | (wdata_next & wmask);
                OFS_DIN_HI: if (wstrb_next[0]) din_next[WORD_W-1:32] = wdata_next[WORD_W-33:0];
                OFS_SETREQ: if (wstrb_next[0]) set_req = wdata_next[NFLAG-1:0];
                OFS_LEVEL:  if (wstrb_next[0]) level_next = wdata_next[NLEVEL-1:0];
                OFS_STAT:   if (wstrb_next[1]) evt_next = evt_reg & ~wdata_next[STAT_EVT_LSB +: NEVT];
                default:    evt_next = evt_reg;
            endcase
        end
        // Set wins over a write-one clear
        evt_next = evt_next | evt_in;
        // Clear first, load 1 us later from the settled bus
        if (pulse_edge.output_clear) begin
            dout_next = '0;
        end
        if (pulse_edge.output_load) begin
            dout_next = buffered_host_output_word_i;
        end
        // General reset overrides software writes to input word and level
        if (pulse_edge.general_reset) begin
            din_next   = DIN_RST;
            level_next = LEVEL_RST;
            dout_next  = DOUT_RST;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            din_reg   <= DIN_RST;
            level_reg <= LEVEL_RST;
            dout_reg  <= DOUT_RST;
            evt_reg   <= EVT_RST;
            ctrl_reg  <= '0;
        end else begin
            din_reg   <= din_next;
            level_reg <= level_next;
            dout_reg  <= dout_next;
            evt_reg   <= evt_next;
            ctrl_reg  <= control_flag_out_i;
        end
    end

    assign user_input_word_o = din_reg;
    assign status_level_o    = level_reg;

    gpu_set_pulser u_pulser (
        .mclk_i    (mclk_i),
        .rst_n_i   (rst_n_i),
        .clear_i   (pulse_edge.general_reset),
        .req_i     (set_req),
        .pending_o (set_pending),
        .set_o     (status_set_o)
    );

    // ************************************************
    // Read channel
    // ************************************************
    gpu_bstate_t rs_reg, rs_next;
    logic        arready_reg, arready_next;
    logic        rvalid_reg, rvalid_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [1:0]  rresp_reg, rresp_next;
    logic [31:0] rmux;

    always_comb begin
        rmux = 32'h0000_0000;
        unique case (s_axi_araddr_i)
            OFS_DIN_LO:  rmux = din_reg[31:0];
            OFS_DIN_HI:  rmux[WORD_W-33:0] = din_reg[WORD_W-1:32];
            OFS_SETREQ:  rmux[NFLAG-1:0] = set_pending | status_set_o;
            OFS_LEVEL:   rmux[NLEVEL-1:0] = level_reg;
            OFS_DOUT_LO: rmux = dout_reg[31:0];
            OFS_DOUT_HI: rmux[WORD_W-33:0] = dout_reg[WORD_W-1:32];
            OFS_STAT: begin
                rmux[STAT_CTRL_LSB +: NCTRL] = ctrl_reg;
                rmux[STAT_EVT_LSB +: NEVT]   = evt_reg;
            end
            default:     rmux = 32'h0000_0000;
        endcase
    end

    always_comb begin
        rs_next      = rs_reg;
        arready_next = arready_reg;
        rvalid_next  = rvalid_reg;
        rdata_next   = rdata_reg;
        rresp_next   = rresp_reg;
        unique case (rs_reg)
            BS_IDLE: begin
                if (s_axi_arvalid_i) begin
                    rs_next      = BS_RESP;
                    arready_next = 1'b0;
                    rvalid_next  = 1'b1;
                    rdata_next   = rmux;
                    rresp_next   = map_hit(s_axi_araddr_i) ? RESP_OKAY : RESP_SLVERR;
                end
            end
            BS_RESP: begin
                if (s_axi_rready_i) begin
                    rs_next      = BS_IDLE;
                    arready_next = 1'b1;
                    rvalid_next  = 1'b0;
                end
            end
            default: begin
                rs_next = BS_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            rs_reg      <= BS_IDLE;
            arready_reg <= 1'b1;
            rvalid_reg  <= 1'b0;
            rdata_reg   <= '0;
            rresp_reg   <= RESP_OKAY;
        end else begin
            rs_reg      <= rs_next;
            arready_reg <= arready_next;
            rvalid_reg  <= rvalid_next;
            rdata_reg   <= rdata_next;
            rresp_reg   <= rresp_next;
        end
    end

    assign s_axi_awready_o = awready_reg;
    assign s_axi_wready_o  = wready_reg;
    assign s_axi_bvalid_o  = bvalid_reg;
    assign s_axi_bresp_o   = bresp_reg;
    assign s_axi_arready_o = arready_reg;
    assign s_axi_rvalid_o  = rvalid_reg;
    assign s_axi_rdata_o   = rdata_reg;
    assign s_axi_rresp_o   = rresp_reg;

    // ************************************************
    // Checks
    // ************************************************
    a_dout_clear: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        pulse_edge.output_clear && !pulse_edge.output_load |=> dout_reg == '0)
        else $error("Output word not cleared");
    a_dout_load: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        pulse_edge.output_load && !pulse_edge.general_reset
        |=> dout_reg == $past(buffered_host_output_word_i))
        else $error("Output word not loaded");
    a_reset_start: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        $rose(dev_pulse_i.general_reset) |=> din_reg == '0 && level_reg == '0 && evt_reg[2])
        else $error("General reset did not clear state");
    a_icomp_sticky: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        $rose(dev_pulse_i.input_complete) |=> evt_reg[0] [*2])
        else $error("Read-done event lost");
    a_bvalid_hold: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
        else $error("Write response dropped");
    a_rvalid_hold: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
        else $error("Read data dropped");

endmodule

// file: sim/gpu_dev_model.sv
`timescale 1ns/1ps
module gpu_dev_model
    import gpu_pkg::*;
#(
    // Flags that may interrupt, flags cleared by data read and by data write
    parameter logic [NFLAG-1:0] PI_EN  = 6'h01,
    parameter logic [NFLAG-1:0] CLR_RD = 6'h02,
    parameter logic [NFLAG-1:0] CLR_WR = 6'h04
)
(
    // Clock
    input  wire logic              mclk_i,
    // From user side
    input  wire logic [WORD_W-1:0] word_i,
    input  wire logic [NFLAG-1:0]  set_i,
    // To user side
    output logic      [WORD_W-1:0] bus_o,
    output logic      [NCTRL-1:0]  ctrl_o,
    output gpu_dev_pulse_t         pulse_o
);
    // ****
    // Device state
    // ****
    logic [WORD_W-1:0] host_word = '0;
    logic [NFLAG-1:0]  flags     = '0;
    logic [NFLAG-1:0]  fclr      = '0;
    logic [2:0]        pich      = '0;
    logic              pi_req;
    logic [5:0]        p         = '0;
    initial bus_o = '0;
    initial ctrl_o = '0;
    assign pulse_o = gpu_dev_pulse_t'(p);
    // Clear and set in one process keeps a single driver
    always @(posedge mclk_i) flags <= (flags & ~fclr) | set_i;
    assign pi_req = |(flags & PI_EN);
    function automatic logic [WORD_W-1:0] stat_word(input logic [NLEVEL-1:0] lev);
        stat_word = {pich, flags, ctrl_o, lev, 18'h0_0000};
    endfunction
    task automatic pulse(input logic [5:0] msk, input int gap);
        p <= msk;
        repeat (13) @(posedge mclk_i);
        p <= '0;
        repeat (gap) @(posedge mclk_i);
    endtask
    task automatic dread();
        host_word = word_i;
        fclr <= CLR_RD;
        pulse(6'h20, 2);
        fclr <= '0;
    endtask
    task automatic dwrite(input logic [WORD_W-1:0] w);
        bus_o <= w;
        repeat (50) @(posedge mclk_i);
        fclr <= CLR_WR;
        pulse(6'h10, 112);
        fclr <= '0;
        pulse(6'h08, 2);
        // Inverse after load catches late sampling
        bus_o <= ~w;
    endtask
    task automatic cwrite(input logic [WORD_W-1:0] w);
        bus_o <= w;
        repeat (50) @(posedge mclk_i);
        // Flags change at the pulses, long before anyone reads them
        ctrl_o <= '0;
        pich   <= '0;
        fclr   <= w[32:27];
        pulse(6'h02, 112);
        fclr   <= '0;
        ctrl_o <= w[26:21];
        pich   <= w[35:33];
        pulse(6'h01, 2);
        bus_o <= ~w;
    endtask
    task automatic greset();
        ctrl_o <= '0;
        pich   <= '0;
        fclr   <= '1;
        pulse(6'h06, 2);
        fclr   <= '0;
    endtask
endmodule

// file: sim/test_gpu_user.sv
`timescale 1ns/1ps
module test_gpu_user
    import gpu_pkg::*;
;
    // ****
    // Bench signals
    // ****
    logic              mclk_i  = 1'b0;
    logic              rst_n_i = 1'b0;
    logic [AXI_AW-1:0] awaddr  = '0;
    logic [AXI_AW-1:0] araddr  = '0;
    logic [31:0]       wdata   = '0;
    logic              awvalid = 1'b0;
    logic              wvalid  = 1'b0;
    logic              bready  = 1'b0;
    logic              arvalid = 1'b0;
    logic              rready  = 1'b0;
    logic              awready, wready, bvalid, arready, rvalid;
    logic [1:0]        bresp, rresp, rr;
    logic [31:0]       rdata, rd;
    logic [WORD_W-1:0] uiw, bus;
    logic [NFLAG-1:0]  sset;
    logic [NLEVEL-1:0] slev;
    logic [NCTRL-1:0]  ctrl;
    gpu_dev_pulse_t    pls;
    int                err_count = 0;
    int                tests_run = 0;
    int                cyc = 0;
    int                n;
    always #4 mclk_i = ~mclk_i;
    gpu_user i_dut (
        .mclk_i(mclk_i), .rst_n_i(rst_n_i),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
        .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
        .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
        .user_input_word_o(uiw), .status_set_o(sset), .status_level_o(slev),
        .buffered_host_output_word_i(bus), .control_flag_out_i(ctrl), .dev_pulse_i(pls));
    gpu_dev_model i_dev (.mclk_i(mclk_i), .word_i(uiw), .set_i(sset), .bus_o(bus), .ctrl_o(ctrl), .pulse_o(pls));
    // ****
    // Tasks
    // ****
    task automatic cmpv(input logic [35:0] got, input logic [35:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge mclk_i);
            if (bvalid === 1'b1) break;
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end
        bready <= 1'b0;
        cmpv(36'(bresp), 36'(er));
        // One edge between calls, so no signal is driven twice at once
        @(posedge mclk_i);
    endtask
    task automatic chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge mclk_i);
            if (rvalid === 1'b1) break;
            if (arready === 1'b1) arvalid <= 1'b0;
        end
        rd = rdata;
        rr = rresp;
        rready <= 1'b0;
        cmpv(36'(rd), 36'(e));
        cmpv(36'(rr), 36'(er));
        @(posedge mclk_i);
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Hang guard, far above the few hundred cycles needed
    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            test_done();
        end
    end
    initial begin
        repeat (5) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        @(posedge mclk_i);
        chk(OFS_DIN_LO, 32'h0000_0000, RESP_OKAY);
        chk(OFS_STAT, 32'h0000_0000, RESP_OKAY);
        cmpv(36'(slev), 36'h0_0000_0000);
        $display("test reset done");
        axw(OFS_DIN_LO, 32'h1234_5678, RESP_OKAY);
        axw(OFS_DIN_HI, 32'h0000_000A, RESP_OKAY);
        i_dev.dread();
        cmpv(i_dev.host_word, 36'hA_1234_5678);
        chk(OFS_STAT, 32'h0000_0100, RESP_OKAY);
        axw(OFS_STAT, 32'h0000_0F00, RESP_OKAY);
        axw(OFS_LEVEL, 32'h0000_0005, RESP_OKAY);
        cmpv(36'(slev), 36'h0_0000_0005);
        $display("test read done");
        i_dev.dwrite(36'h5_8765_4321);
        chk(OFS_DOUT_LO, 32'h8765_4321, RESP_OKAY);
        chk(OFS_DOUT_HI, 32'h0000_0005, RESP_OKAY);
        chk(OFS_STAT, 32'h0000_0200, RESP_OKAY);
        axw(OFS_STAT, 32'h0000_0F00, RESP_OKAY);
        i_dev.cwrite(36'h0_05A0_0000);
        chk(OFS_STAT, 32'h0000_082D, RESP_OKAY);
        $display("test write done");
        axw(OFS_SETREQ, 32'h0000_0001, RESP_OKAY);
        while (sset[0] !== 1'b1) @(posedge mclk_i);
        n = cyc;
        while (sset[0] === 1'b1) @(posedge mclk_i);
        cmpv(36'(cyc - n), 36'h0_0000_000D);
        n = cyc;
        axw(OFS_SETREQ, 32'h0000_0001, RESP_OKAY);
        while (sset[0] !== 1'b1) @(posedge mclk_i);
        cmpv(36'(cyc - n >= 50), 36'h0_0000_0001);
        cmpv(36'(i_dev.flags), 36'h0_0000_0001);
        cmpv(36'(i_dev.pi_req), 36'h0_0000_0001);
        cmpv(i_dev.stat_word(slev), 36'h0_0DB4_0000);
        $display("test set done");
        i_dev.greset();
        cmpv(36'(i_dev.pi_req), 36'h0_0000_0000);
        chk(OFS_DIN_LO, 32'h0000_0000, RESP_OKAY);
        chk(OFS_STAT, 32'h0000_0C00, RESP_OKAY);
        cmpv(36'(slev), 36'h0_0000_0000);
        axw(OFS_DOUT_LO, 32'hFFFF_FFFF, RESP_OKAY);
        chk(OFS_DOUT_LO, 32'h0000_0000, RESP_OKAY);
        chk(8'h1C, 32'h0000_0000, RESP_SLVERR);
        axw(8'h20, 32'h0000_0001, RESP_SLVERR);
        $display("test reset pulse done");
        test_done();
    end
endmodule
